/* cemlc_engine.sv */
// Purpose: Engine end: self-test, lock, mode switching, key stores, data path
// Assumes: kat_fault_inject is an asynchronous pin; all else on clk_sys
// Notes:   The transform stands in for the real algorithms
//
// Notes on behaviour
// [RULE1] Approved mode only after all self-tests pass
// [RULE2] Non-approved request switches mode by itself
// [RULE3] Back to approved mode right after service
// [RULE4] Separate key stores for each mode
// [RULE5] No service before init and self-tests finish
// [RULE6] Failed known-answer test locks the engine
// [RULE7] Only reset clears lock and reruns tests
// [RULE8] Key registers are write-only, read zero
// [RULE9] Reset clears all keys and secrets
// [RULE10] Data through FIFOs, control and status registers
// [RULE11] Keys load by register or FIFO word
// [RULE12] Requester sends parameters and data by DMA
// [RULE13] Non-approved use needs fresh key first
// [RULE14] No output without the transform applied
// [RULE15] Errors never expose secret material
// [RULE16] Requester keeps IVs unique, ops per key bounded
// [RULE17] Status shows testing, passed and locked

`timescale 1ns/10ps
`default_nettype none

module cemlc_engine
  import cemlc_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   ce,
  input  wire logic   kat_fault_inject,
  cemlc_link_if.eng   lnk,
  output logic        approved_mode,
  output logic        locked
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cemlc_state_type st_q, st_d;
  logic            kat_idx_q, kat_idx_d;
  logic [LENW-1:0] rem_q, rem_d;
  logic            nap_q, nap_d;
  logic            pass_q, pass_d;
  logic            err_q, err_d;
  logic            en_q, en_d;
  logic [DW-1:0]   key_app_q, key_app_d;
  logic [DW-1:0]   key_nap_q, key_nap_d;
  logic [DW-1:0]   rdata_q, rdata_d;
  logic            rvalid_q, rvalid_d;
  logic            flt_s1_q, flt_s2_q;
  logic            in_fire, err_set, err_clr, kat_bad;
  logic            buf_ready, push_valid;
  logic [DW-1:0]   push_data, key_sel, kat_res, kat_exp;
  logic [DW-1:0]   status_w;

  // Fault pin is asynchronous, so two flops before anything reads it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
    end else if (ce) begin
      flt_s1_q <= kat_fault_inject;
      flt_s2_q <= flt_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Self-test datapath
  // ----------------------------------------------------------------------
  // Same transform as the run path, so the test covers the real logic
  always_comb begin
    if (kat_idx_q) begin
      kat_res = cemlc_mix(KAT_IN1, KAT_KEY1);
      kat_exp = KAT_EXP1;
    end else begin
      kat_res = cemlc_mix(KAT_IN0, KAT_KEY0);
      kat_exp = KAT_EXP0;
    end
    kat_bad = (kat_res != kat_exp) | flt_s2_q;
  end

  // ----------------------------------------------------------------------
  // Inbound handshake and outbound data path
  // ----------------------------------------------------------------------
  // Nothing is taken during init or test; see [RULE5]
  always_comb begin
    case (st_q)
      ST_IDLE, ST_LOCK: lnk.in_ready = 1'b1;
      ST_RUN:  lnk.in_ready = (lnk.in_kind == KIND_PAYLOAD) ? buf_ready : 1'b1;
      default: lnk.in_ready = 1'b0;
    endcase
  end

  assign in_fire    = lnk.in_valid & lnk.in_ready & ce;
  assign key_sel    = nap_q ? key_nap_q : key_app_q;            // see [RULE4]
  assign push_valid = (st_q == ST_RUN) & lnk.in_valid
                    & (lnk.in_kind == KIND_PAYLOAD);
  assign push_data  = cemlc_mix(lnk.in_data, key_sel);          // see [RULE14]

  // Results leave only through the buffer; see [RULE10]
  cemlc_buf2 #(
    .WIDTH (DW)
  ) u_obuf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push_valid),
    .in_ready  (buf_ready),
    .in_data   (push_data),
    .out_valid (lnk.out_valid),
    .out_ready (lnk.out_ready),
    .out_data  (lnk.out_data)
  );

  // ----------------------------------------------------------------------
  // Control state machine, key stores and error flag
  // ----------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    kat_idx_d = kat_idx_q;
    rem_d     = rem_q;
    nap_d     = nap_q;
    pass_d    = pass_q;
    en_d      = en_q;
    key_app_d = key_app_q;
    key_nap_d = key_nap_q;
    err_set   = 1'b0;
    err_clr   = 1'b0;
    case (st_q)
      ST_INIT: begin
        key_app_d = ZERO_W;                                     // see [RULE9]
        key_nap_d = ZERO_W;                                     // see [RULE9]
        pass_d    = 1'b0;
        nap_d     = 1'b0;
        kat_idx_d = 1'b0;
        st_d      = ST_TEST;                                    // see [RULE7]
      end
      ST_TEST: begin
        if (kat_bad) begin
          st_d = ST_LOCK;                                       // see [RULE6]
        end else if (kat_idx_q == KAT_LAST) begin
          st_d   = ST_IDLE;                                     // see [RULE1]
          pass_d = 1'b1;
        end else begin
          kat_idx_d = ~kat_idx_q;
        end
      end
      ST_IDLE: begin
        if (in_fire) begin
          case (lnk.in_kind)
            KIND_PARAM: begin
              if (en_q && (lnk.in_data[LENW-1:0] != LEN_ZERO)) begin
                st_d  = ST_RUN;
                rem_d = lnk.in_data[LENW-1:0];
                nap_d = lnk.in_data[PRM_NAP_BIT];               // see [RULE2]
              end else begin
                err_set = 1'b1;
              end
            end
            KIND_KEY_APP: key_app_d = lnk.in_data;              // see [RULE11]
            KIND_KEY_NAP: key_nap_d = lnk.in_data;              // see [RULE11]
            default:      err_set   = 1'b1;                     // see [RULE14]
          endcase
        end
      end
      ST_RUN: begin
        if (in_fire) begin
          if (lnk.in_kind == KIND_PAYLOAD) begin
            rem_d = rem_q - LEN_ONE;
            if (rem_q == LEN_ONE) begin
              st_d  = ST_IDLE;
              nap_d = 1'b0;                                     // see [RULE3]
            end
          end else begin
            err_set = 1'b1;
          end
        end
      end
      ST_LOCK: begin
        // Words are drained and dropped so the DMA cannot hang
        if (in_fire) begin
          err_set = 1'b1;                                       // see [RULE6]
        end
      end
      default: st_d = ST_INIT;
    endcase
    // Register writes; keys only change while idle
    if (lnk.reg_wr) begin
      if (lnk.reg_addr == REG_CTRL) begin
        en_d = lnk.reg_wdata[CTRL_EN_BIT];
      end else if (lnk.reg_addr == REG_STATUS) begin
        err_clr = lnk.reg_wdata[ST_ERR_BIT];
      end else if (lnk.reg_addr == REG_KEY_APP) begin
        if (st_q == ST_IDLE) key_app_d = lnk.reg_wdata;         // see [RULE11]
        else err_set = 1'b1;
      end else if (lnk.reg_addr == REG_KEY_NAP) begin
        if (st_q == ST_IDLE) key_nap_d = lnk.reg_wdata;         // see [RULE11]
        else err_set = 1'b1;
      end
    end
    // A new error in the clearing cycle is kept
    err_d = err_set | (err_q & ~err_clr);
  end

  // Sync reset wipes keys at once; see [RULE9]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q      <= ST_INIT;                                     // see [RULE7]
      kat_idx_q <= 1'b0;
      rem_q     <= LEN_ZERO;
      nap_q     <= 1'b0;
      pass_q    <= 1'b0;
      err_q     <= 1'b0;
      en_q      <= 1'b0;
      key_app_q <= ZERO_W;
      key_nap_q <= ZERO_W;
    end else if (ce) begin
      st_q      <= st_d;
      kat_idx_q <= kat_idx_d;
      rem_q     <= rem_d;
      nap_q     <= nap_d;
      pass_q    <= pass_d;
      err_q     <= err_d;
      en_q      <= en_d;
      key_app_q <= key_app_d;
      key_nap_q <= key_nap_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Status holds only state flags, never key bits; see [RULE15]
  always_comb begin
    status_w               = ZERO_W;
    status_w[ST_TBUSY_BIT] = (st_q == ST_INIT) | (st_q == ST_TEST);  // see [RULE17]
    status_w[ST_PASS_BIT]  = pass_q;                            // see [RULE17]
    status_w[ST_LOCK_BIT]  = (st_q == ST_LOCK);                 // see [RULE17]
    status_w[ST_NAP_BIT]   = nap_q;
    status_w[ST_BUSY_BIT]  = (st_q == ST_RUN);
    status_w[ST_ERR_BIT]   = err_q;
  end

  always_comb begin
    rvalid_d = lnk.reg_rd;
    rdata_d  = ZERO_W;                                          // see [RULE8]
    if (lnk.reg_rd) begin
      if (lnk.reg_addr == REG_CTRL) begin
        rdata_d[CTRL_EN_BIT] = en_q;
      end else if (lnk.reg_addr == REG_STATUS) begin
        rdata_d = status_w;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q  <= ZERO_W;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign lnk.reg_rdata  = rdata_q;
  assign lnk.reg_rvalid = rvalid_q;
  assign approved_mode  = pass_q & ~nap_q & ((st_q == ST_IDLE) | (st_q == ST_RUN));
  assign locked         = (st_q == ST_LOCK);

endmodule

`default_nettype wire

/* cemlc_pkg.sv */
// Purpose: Shared constants and types for the engine mode and lock control shell
// Assumes: One 40 MHz clock, synchronous active-high reset
// Notes:   Register offsets, word kinds, status fields and self-test vectors

package cemlc_pkg;

  // ----------------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DW     = 32;
  localparam int unsigned AW     = 8;
  localparam int unsigned LENW   = 16;
  localparam int unsigned OPSW   = 33;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] REG_CTRL    = 8'h00;
  localparam logic [AW-1:0] REG_STATUS  = 8'h04;
  localparam logic [AW-1:0] REG_KEY_APP = 8'h08;
  localparam logic [AW-1:0] REG_KEY_NAP = 8'h0C;

  // Control and status field positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned ST_TBUSY_BIT = 0;
  localparam int unsigned ST_PASS_BIT  = 1;
  localparam int unsigned ST_LOCK_BIT  = 2;
  localparam int unsigned ST_NAP_BIT   = 3;
  localparam int unsigned ST_BUSY_BIT  = 4;
  localparam int unsigned ST_ERR_BIT   = 5;

  // Parameter word: bit 31 asks for a non-approved service, low bits the length
  localparam int unsigned PRM_NAP_BIT = 31;
  localparam logic [LENW-1:0] LEN_ONE  = 16'h0001;
  localparam logic [LENW-1:0] LEN_ZERO = 16'h0000;

  // Inbound word kinds
  typedef enum logic [1:0] {
    KIND_PAYLOAD = 2'h0,
    KIND_PARAM   = 2'h1,
    KIND_KEY_APP = 2'h2,
    KIND_KEY_NAP = 2'h3
  } cemlc_kind_type;

  // Engine states, Gray coded along init, test, idle, run
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_TEST = 3'h1,
    ST_IDLE = 3'h3,
    ST_RUN  = 3'h2,
    ST_LOCK = 3'h6
  } cemlc_state_type;

  // ----------------------------------------------------------------------
  // Datapath transform and known-answer vectors
  // ----------------------------------------------------------------------
  localparam logic [DW-1:0] MIX_C    = 32'h5A5A_5A5A;
  localparam logic [DW-1:0] ZERO_W   = 32'h0000_0000;
  localparam logic          KAT_LAST = 1'b1;
  localparam logic [DW-1:0] KAT_IN0  = 32'h0000_0001;
  localparam logic [DW-1:0] KAT_KEY0 = 32'h0000_0000;
  localparam logic [DW-1:0] KAT_EXP0 = 32'h5A5A_5B5A;
  localparam logic [DW-1:0] KAT_IN1  = 32'h1000_0000;
  localparam logic [DW-1:0] KAT_KEY1 = 32'h0000_00FF;
  localparam logic [DW-1:0] KAT_EXP1 = 32'h5A5A_5AB5;

  // Keyed word transform shared by the run path and the self-test
  function automatic logic [DW-1:0] cemlc_mix(input logic [DW-1:0] d,
                                              input logic [DW-1:0] k);
    cemlc_mix = {d[23:0], d[31:24]} ^ k ^ MIX_C;
  endfunction

endpackage

/* cemlc_link_if.sv */
// Purpose: Link between the engine and its DMA and software side
// Assumes: Both ends run on clk_sys
// Notes:   Register port plus inbound and outbound word streams

`timescale 1ns/10ps
`default_nettype none

interface cemlc_link_if;
  import cemlc_pkg::*;

  // ----------------------------------------------------------------------
  // Register port and data streams
  // ----------------------------------------------------------------------
  logic                 reg_wr;
  logic                 reg_rd;
  logic [AW-1:0]        reg_addr;
  logic [DW-1:0]        reg_wdata;
  logic [DW-1:0]        reg_rdata;
  logic                 reg_rvalid;
  logic                 in_valid;
  logic                 in_ready;
  cemlc_kind_type       in_kind;
  logic [DW-1:0]        in_data;
  logic                 out_valid;
  logic                 out_ready;
  logic [DW-1:0]        out_data;

  modport eng (
    input  reg_wr, reg_rd, reg_addr, reg_wdata, in_valid, in_kind, in_data, out_ready,
    output reg_rdata, reg_rvalid, in_ready, out_valid, out_data
  );

  modport dma (
    output reg_wr, reg_rd, reg_addr, reg_wdata, in_valid, in_kind, in_data, out_ready,
    input  reg_rdata, reg_rvalid, in_ready, out_valid, out_data
  );

endinterface

`default_nettype wire

/* cemlc_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes:   Output data comes straight from the storage flops

`timescale 1ns/10ps
`default_nettype none

module cemlc_buf2
  import cemlc_pkg::*;
#(
  parameter int unsigned WIDTH = DW
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic             wp_q, wp_d, rp_q, rp_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  // Honest full and empty; a stalled reader backs up to the writer
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready & ce;
  assign pop       = out_valid & out_ready & ce;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  // Storage is cleared at reset so no stale result survives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else if (ce) begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

/* cemlc_dma.sv */
// Purpose: DMA and software end: register access and gated inbound stream
// Assumes: User side and engine share clk_sys
// Notes:   Holds back requests that would break the requester's duties

`timescale 1ns/10ps
`default_nettype none

module cemlc_dma
  import cemlc_pkg::*;
#(
  parameter logic [OPSW-1:0] OPS_LIMIT = 33'h1_0000_0000
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire logic           ce,
  cemlc_link_if.dma           lnk,
  input  wire logic           usr_reg_wr,
  input  wire logic           usr_reg_rd,
  input  wire logic [AW-1:0]  usr_reg_addr,
  input  wire logic [DW-1:0]  usr_reg_wdata,
  output logic      [DW-1:0]  usr_reg_rdata,
  output logic                usr_reg_rvalid,
  input  wire logic           usr_in_valid,
  output logic                usr_in_ready,
  input  wire cemlc_kind_type usr_in_kind,
  input  wire logic [DW-1:0]  usr_in_data,
  output logic                usr_out_valid,
  input  wire logic           usr_out_ready,
  output logic      [DW-1:0]  usr_out_data,
  output logic                usr_refused
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic            wr_q, wr_d, rd_q, rd_d;
  logic [AW-1:0]   addr_q, addr_d;
  logic [DW-1:0]   wdata_q, wdata_d, rdat_q, rdat_d;
  logic            rval_q, rval_d;
  logic            hv_q, hv_d;
  cemlc_kind_type  hk_q, hk_d;
  logic [DW-1:0]   hd_q, hd_d;
  logic [OPSW-1:0] ops_q, ops_d;
  logic            fresh_q, fresh_d;
  logic            ref_q, ref_d;
  logic            take, is_prm, is_nap, block;

  // ----------------------------------------------------------------------
  // Register path, one flop stage each way
  // ----------------------------------------------------------------------
  always_comb begin
    wr_d    = usr_reg_wr;
    rd_d    = usr_reg_rd;
    addr_d  = usr_reg_addr;
    wdata_d = usr_reg_wdata;
    rval_d  = lnk.reg_rvalid;
    rdat_d  = lnk.reg_rvalid ? lnk.reg_rdata : rdat_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= REG_CTRL;
      wdata_q <= ZERO_W;
      rval_q  <= 1'b0;
      rdat_q  <= ZERO_W;
    end else if (ce) begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rval_q  <= rval_d;
      rdat_q  <= rdat_d;
    end
  end

  // ----------------------------------------------------------------------
  // Inbound stage with request gating
  // ----------------------------------------------------------------------
  // Parameters and data travel only by the stream; see [RULE12]
  assign usr_in_ready = ~hv_q | lnk.in_ready;
  assign take         = usr_in_valid & usr_in_ready & ce;
  assign is_prm       = (usr_in_kind == KIND_PARAM);
  assign is_nap       = usr_in_data[PRM_NAP_BIT];
  // Non-approved use needs a fresh key, and each key has bounded use
  assign block        = is_prm & ((is_nap & ~fresh_q)           // see [RULE13]
                      | (ops_q >= OPS_LIMIT));                  // see [RULE16]

  always_comb begin
    hv_d    = hv_q & ~lnk.in_ready;
    hk_d    = hk_q;
    hd_d    = hd_q;
    ops_d   = ops_q;
    fresh_d = fresh_q;
    ref_d   = ref_q;
    if (take) begin
      if (block) begin
        ref_d = 1'b1;
      end else begin
        hv_d = 1'b1;
        hk_d = usr_in_kind;
        hd_d = usr_in_data;
        if (usr_in_kind == KIND_KEY_APP || usr_in_kind == KIND_KEY_NAP) begin
          ops_d = '0;                                           // see [RULE11]
        end
        if (usr_in_kind == KIND_KEY_NAP) fresh_d = 1'b1;
        if (is_prm) begin
          ops_d = ops_q + OPSW'(1);
          if (is_nap) fresh_d = 1'b0;
        end
      end
    end
    // Key loads over the register path count as fresh keys too
    if (usr_reg_wr && (usr_reg_addr == REG_KEY_APP || usr_reg_addr == REG_KEY_NAP)) begin
      ops_d = '0;
      if (usr_reg_addr == REG_KEY_NAP) fresh_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hv_q    <= 1'b0;
      hk_q    <= KIND_PAYLOAD;
      hd_q    <= ZERO_W;
      ops_q   <= '0;
      fresh_q <= 1'b0;
      ref_q   <= 1'b0;
    end else if (ce) begin
      hv_q    <= hv_d;
      hk_q    <= hk_d;
      hd_q    <= hd_d;
      ops_q   <= ops_d;
      fresh_q <= fresh_d;
      ref_q   <= ref_d;
    end
  end

  // ----------------------------------------------------------------------
  // Link drive and outbound pass-through
  // ----------------------------------------------------------------------
  assign lnk.reg_wr     = wr_q;
  assign lnk.reg_rd     = rd_q;
  assign lnk.reg_addr   = addr_q;
  assign lnk.reg_wdata  = wdata_q;
  assign lnk.in_valid   = hv_q;
  assign lnk.in_kind    = hk_q;
  assign lnk.in_data    = hd_q;
  assign lnk.out_ready  = usr_out_ready;
  assign usr_out_valid  = lnk.out_valid;
  assign usr_out_data   = lnk.out_data;
  assign usr_reg_rdata  = rdat_q;
  assign usr_reg_rvalid = rval_q;
  assign usr_refused    = ref_q;

endmodule

`default_nettype wire

/* cemlc_asserts.sv */
// Purpose: Link checker for the engine and DMA ends
// Assumes: One clock, rst synchronous high
// Notes:   Sees only the link signals
`timescale 1ns/10ps
`default_nettype none
module cemlc_asserts
  import cemlc_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst,
  input wire logic           reg_rd,
  input wire logic [AW-1:0]  reg_addr,
  input wire logic [DW-1:0]  reg_rdata,
  input wire logic           reg_rvalid,
  input wire logic           in_valid,
  input wire logic           in_ready,
  input wire cemlc_kind_type in_kind,
  input wire logic           out_valid,
  input wire logic           out_ready,
  input wire logic [DW-1:0]  out_data
);
  // ------------
  // Link rules
  // ------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Reads answer one cycle late, never unasked
  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_rv_src; reg_rvalid |-> $past(reg_rd); endproperty
  a_rv_src: assert property (p_rv_src) else $error("stray answer");
  // Key stores must never be read back
  property p_key_wo;
    reg_rd && (reg_addr == REG_KEY_APP || reg_addr == REG_KEY_NAP) |=> reg_rdata == ZERO_W;
  endproperty
  a_key_wo: assert property (p_key_wo) else $error("key read back");
  property p_rd_quiet; !reg_rvalid |-> reg_rdata == ZERO_W; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("data leaks");
  // No service while init and self-test run, then ready soon after
  property p_boot; $fell(rst) |-> !in_ready [*3]; endproperty
  a_boot: assert property (p_boot) else $error("ready too early");
  property p_ready; $fell(rst) |-> ##[3:12] in_ready; endproperty
  a_ready: assert property (p_ready) else $error("never ready");
  // An output word only follows a taken payload word
  property p_no_byp;
    $rose(out_valid) |-> $past(in_valid && in_ready && in_kind == KIND_PAYLOAD);
  endproperty
  a_no_byp: assert property (p_no_byp) else $error("word without payload");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled word lost");
  c_stall: cover property (out_valid && !out_ready);
  c_keyrd: cover property (reg_rd && reg_addr == REG_KEY_APP);
  c_boot: cover property ($fell(rst));
endmodule
`default_nettype wire

/* crypto_engine_mode_lock_control_bench.sv */
// Purpose: Self-checking bench for both ends
// Assumes: 40 MHz clk_sys, rst synchronous high
// Notes:   Expected words queue up, monitors compare
`timescale 1ns/10ps
`default_nettype none
module crypto_engine_mode_lock_control_bench;
  import cemlc_pkg::*;
  logic           clk_sys = 1'b0;
  logic           rst = 1'b1;
  logic           flt = 1'b0;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic [AW-1:0]  ad = 8'h00;
  logic [DW-1:0]  wd = ZERO_W;
  logic           iv = 1'b0;
  cemlc_kind_type kd = KIND_PAYLOAD;
  logic [DW-1:0]  id = ZERO_W;
  logic           ordy = 1'b0;
  logic [DW-1:0]  seed = 32'h0001_04B8;
  logic [DW-1:0]  ka, kn;
  wire logic [DW-1:0] rdat, odat;
  wire logic      rv, irdy, ov, refd, am, lk;
  int             err_total = 0;
  int             checked = 0;
  logic [DW-1:0]  ex_q[$];
  logic [DW-1:0]  rd_q[$];
  // ------------
  // Ends
  // ------------
  cemlc_link_if lnk ();
  cemlc_engine u_cemlc_engine (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .kat_fault_inject(flt), .lnk(lnk.eng), .approved_mode(am), .locked(lk));
  cemlc_dma #(.OPS_LIMIT(33'h0_0000_0004)) u_cemlc_dma (.clk_sys(clk_sys), .rst(rst),
    .ce(1'b1), .lnk(lnk.dma), .usr_reg_wr(wr), .usr_reg_rd(rd), .usr_reg_addr(ad),
    .usr_reg_wdata(wd), .usr_reg_rdata(rdat), .usr_reg_rvalid(rv), .usr_in_valid(iv),
    .usr_in_ready(irdy), .usr_in_kind(kd), .usr_in_data(id), .usr_out_valid(ov),
    .usr_out_ready(ordy), .usr_out_data(odat), .usr_refused(refd));
  cemlc_asserts u_cemlc_asserts (.clk_sys(clk_sys), .rst(rst), .reg_rd(lnk.reg_rd),
    .reg_addr(lnk.reg_addr), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid),
    .in_valid(lnk.in_valid), .in_ready(lnk.in_ready), .in_kind(lnk.in_kind),
    .out_valid(lnk.out_valid), .out_ready(lnk.out_ready), .out_data(lnk.out_data));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [DW-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Own copy of the word transform
  function automatic logic [DW-1:0] xf(logic [DW-1:0] d, logic [DW-1:0] k);
    return {d[23:0], d[31:24]} ^ k ^ 32'h5A5A_5A5A;
  endfunction
  task automatic chk(string nm, logic [DW-1:0] seen, logic [DW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rw(logic [AW-1:0] a, logic [DW-1:0] d);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rg(logic [AW-1:0] a, logic [DW-1:0] e);
    rd_q.push_back(e);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Valid stays up across words; settle drops it
  task automatic tx(cemlc_kind_type k, logic [DW-1:0] d);
    iv <= 1'b1;
    kd <= k;
    id <= d;
    do @(posedge clk_sys); while (irdy !== 1'b1);
  endtask
  task automatic run(logic nap, int n, logic [DW-1:0] k);
    logic [DW-1:0] d;
    tx(KIND_PARAM, {nap, 15'h0000, n[15:0]});
    repeat (n) begin
      d = rnd();
      ex_q.push_back(xf(d, k));
      tx(KIND_PAYLOAD, d);
    end
  endtask
  task automatic settle();
    iv <= 1'b0;
    for (int i = 0; i < 300 && ex_q.size() + rd_q.size() > 0; i++) @(posedge clk_sys);
    if (ex_q.size() + rd_q.size() > 0) err_total++;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic boot();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rw(REG_CTRL, 32'h0000_0001);
  endtask
  // Monitors: pop the oldest note per result, stall output at random
  always @(posedge clk_sys) begin
    if (ov && ordy) chk("out", odat, ex_q.size() ? ex_q.pop_front() : 'x);
    if (rv) chk("rdata", rdat, rd_q.size() ? rd_q.pop_front() : 'x);
    ordy <= rnd() > 32'h5000_0000;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
  initial begin
    boot();
    chk("approved", am, 1);
    rg(REG_STATUS, 32'h0000_0002);
    ka = rnd();
    kn = rnd();
    rw(REG_KEY_APP, ka);
    rg(REG_KEY_APP, ZERO_W);
    tx(KIND_KEY_NAP, kn);
    run(1'b0, 3, ka);
    run(1'b1, 2, kn);
    run(1'b0, 1, ka);
    settle();
    $display("modes and keys done");
    tx(KIND_PARAM, {1'b1, 15'h0000, LEN_ONE});
    settle();
    chk("refused", refd, 1);
    $display("refusal done");
    boot();
    run(1'b0, 1, ZERO_W);
    settle();
    $display("zeroize done");
    flt <= 1'b1;
    boot();
    chk("locked", lk, 1);
    rg(REG_STATUS, 32'h0000_0004);
    tx(KIND_PAYLOAD, rnd());
    settle();
    flt <= 1'b0;
    boot();
    chk("unlocked", lk, 0);
    rg(REG_STATUS, 32'h0000_0002);
    settle();
    $display("lock done");
    end_of_test();
  end
endmodule
`default_nettype wire
